// [adc_flag_cfg.svh]
`ifndef ADC_FLAG_CFG_SVH
`define ADC_FLAG_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define ADC_NCH 4
`define ADC_DW 10
`define ADC_CHW 2

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADC_OFS_CTRL 8'h00
`define ADC_OFS_MODE 8'h04
`define ADC_OFS_CHEN 8'h10
`define ADC_OFS_CHDIS 8'h14
`define ADC_OFS_CHSR 8'h18
`define ADC_OFS_STAT 8'h1c
`define ADC_OFS_LAST 8'h20
`define ADC_OFS_CH0 8'h30
`define ADC_OFS_CH_LAST 8'h3c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADC_CTRL_START 0
`define ADC_MODE_LOWPWR 0
`define ADC_STAT_DONE_LSB 0
`define ADC_STAT_OVR_LSB 8
`define ADC_STAT_READY 16
`define ADC_STAT_GOVR 17
`define ADC_LAST_CH_LSB 12

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADC_RST_MODE 1'b0
`define ADC_RST_CHEN 4'h0

`endif

// [adc_flag_pkg.sv]
`include "adc_flag_cfg.svh"

package adc_flag_pkg;
   // Conversion result word
   typedef logic [`ADC_DW-1:0] result_t;
   // Channel number
   typedef logic [`ADC_CHW-1:0] chan_t;
   // Power state of the converter
   typedef enum logic {PWR_ACTIVE, PWR_SLEEP} pwr_state_t;
endpackage

// [adc_result_store.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Per-channel result words, registered read, write-first
// ----------------------------------------------------------------
module adc_result_store #(
   parameter int NCH = 4,
   parameter int DW = 10,
   parameter int AW = 2
) (
   input wire logic ref_clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata_q
);
   logic [DW-1:0] mem_q [NCH];
   logic [DW-1:0] rdata_d;

   // Write-first so a read never returns the word just replaced
   always_comb begin
      rdata_d = mem_q[raddr];
      if (we && (waddr == raddr)) begin
         rdata_d = wdata;
      end
   end

   // Storage has no reset; contents are meaningless until written
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
      rdata_q <= rdata_d;
   end
endmodule

`default_nettype wire

// [adc_sleep_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Deferred low-power entry
// ----------------------------------------------------------------
module adc_sleep_ctrl (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic lowpwr_sel,
   input wire logic start_req,
   input wire logic conv_end,
   output logic sleep_q
);
   import adc_flag_pkg::*;

   pwr_state_t state_q, state_d;

   // Sleep is only taken at the end of a conversion, never while idle
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         PWR_ACTIVE: begin
            if (lowpwr_sel && conv_end) begin
               state_d = PWR_SLEEP;
            end
         end
         PWR_SLEEP: begin
            if (!lowpwr_sel || start_req) begin
               state_d = PWR_ACTIVE;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= PWR_ACTIVE;
         sleep_q <= 1'b0;
      end else begin
         state_q <= state_d;
         sleep_q <= (state_d == PWR_SLEEP);
      end
   end
endmodule

`default_nettype wire

// [adc_result_flag_logic.sv]
// Functional notes
// - Result-ready clears only on a read of the last-converted register.
// - A status read meeting an end of conversion still updates global overrun.
// - A status read clears global overrun when result-ready is idle.
// - A status read clears every channel overrun except one raised by an end in the same cycle.
// - An end on a channel whose done flag is set raises its overrun.
// - Done clears on a read of its channel register or the last register.
// - A channel register read clears that channel's done flag only.
// - A channel disabled mid-conversion never raises its done flag.
// - Result-ready never rises for a result that was not stored.
// - Each enabled end stores the result and raises result-ready.
// - Result-ready rises even when another channel register is read.
// - An end while result-ready is active raises global overrun.
// - Low power selected while idle is entered only after a conversion.
`timescale 1ns/10ps
`default_nettype none
`include "adc_flag_cfg.svh"

module adc_result_flag_logic (
   input wire logic ref_clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter core, same clock
   input wire logic conv_end,
   input wire adc_flag_pkg::chan_t conv_chan,
   input wire adc_flag_pkg::result_t conv_data,
   output logic conv_start,
   output logic [`ADC_NCH-1:0] chan_en,
   output logic sleep
);
   import adc_flag_pkg::*;

   localparam int NCH = `ADC_NCH;

   // ----------------------------------------------------------------
   // Bus phases
   // ----------------------------------------------------------------
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic access;
   logic rd_take;
   logic wr_take;
   logic in_ch;
   logic mapped;
   chan_t rd_idx;

   // Access lasts two cycles; read data and read side effects land
   // together on the first access edge, writes on the completing one
   assign access = psel && penable;
   assign rd_take = access && !pready_q && !pwrite;
   assign wr_take = access && pready_q && pwrite;
   assign in_ch = (paddr >= `ADC_OFS_CH0) && (paddr <= `ADC_OFS_CH_LAST)
                  && (paddr[1:0] == 2'b00);
   assign rd_idx = chan_t'(paddr[`ADC_CHW+1:2]);

   // Address decode
   always_comb begin
      unique case (paddr)
         `ADC_OFS_CTRL, `ADC_OFS_MODE, `ADC_OFS_CHEN, `ADC_OFS_CHDIS,
         `ADC_OFS_CHSR, `ADC_OFS_STAT, `ADC_OFS_LAST: mapped = 1'b1;
         default: mapped = in_ch;
      endcase
   end

   // ----------------------------------------------------------------
   // Read strobes with side effects
   // ----------------------------------------------------------------
   logic rd_stat;
   logic rd_last;
   logic [NCH-1:0] rd_chan;

   assign rd_stat = rd_take && (paddr == `ADC_OFS_STAT);
   assign rd_last = rd_take && (paddr == `ADC_OFS_LAST);

   // One decoded strobe per channel register
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_rd
         assign rd_chan[gi] = rd_take && in_ch && (rd_idx == chan_t'(gi));
      end
   endgenerate

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic mode_lp_q, mode_lp_d;
   logic [NCH-1:0] chen_q, chen_d;
   logic start_q, start_d;
   logic [NCH-1:0] dis_now;

   // Disable written this cycle already blocks an end in this cycle
   assign dis_now = (wr_take && (paddr == `ADC_OFS_CHDIS)) ?
                    pwdata[NCH-1:0] : '0;

   // Next control values
   always_comb begin
      mode_lp_d = mode_lp_q;
      chen_d = chen_q & ~dis_now;
      start_d = 1'b0;
      if (wr_take) begin
         unique case (paddr)
            `ADC_OFS_CTRL: start_d = pwdata[`ADC_CTRL_START];
            `ADC_OFS_MODE: mode_lp_d = pwdata[`ADC_MODE_LOWPWR];
            `ADC_OFS_CHEN: chen_d = chen_q | pwdata[NCH-1:0];
            default: ;
         endcase
      end
   end

   // Control state
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mode_lp_q <= `ADC_RST_MODE;
         chen_q <= `ADC_RST_CHEN;
         start_q <= 1'b0;
      end else begin
         mode_lp_q <= mode_lp_d;
         chen_q <= chen_d;
         start_q <= start_d;
      end
   end

   // ----------------------------------------------------------------
   // End-of-conversion qualification
   // ----------------------------------------------------------------
   logic [NCH-1:0] ch_end;
   logic any_end;

   // Ends on a channel that is off or going off are neither stored nor flagged
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_end
         assign ch_end[gi] = conv_end && (conv_chan == chan_t'(gi))
                             && chen_q[gi] && !dis_now[gi];
      end
   endgenerate
   assign any_end = |ch_end;

   // ----------------------------------------------------------------
   // Result storage
   // ----------------------------------------------------------------
   result_t mem_rdata;
   result_t last_q, last_d;
   chan_t last_ch_q, last_ch_d;

   // Channel words; a store ignores any simultaneous disable elsewhere
   adc_result_store #(
      .NCH(NCH),
      .DW(`ADC_DW),
      .AW(`ADC_CHW)
   ) u_store (
      .ref_clk(ref_clk),
      .we(any_end),
      .waddr(conv_chan),
      .wdata(conv_data),
      .raddr(rd_idx),
      .rdata_q(mem_rdata)
   );

   // Last-converted word follows every stored result
   always_comb begin
      last_d = last_q;
      last_ch_d = last_ch_q;
      if (any_end) begin
         last_d = conv_data;
         last_ch_d = conv_chan;
      end
   end

   // Last-converted register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         last_q <= '0;
         last_ch_q <= '0;
      end else begin
         last_q <= last_d;
         last_ch_q <= last_ch_d;
      end
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   logic [NCH-1:0] done_q, done_d;
   logic [NCH-1:0] ovr_q, ovr_d;
   logic ready_q, ready_d;
   logic govr_q, govr_d;

   // Per-channel done and overrun; a hardware set beats any clear
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_flag
         always_comb begin
            if (ch_end[gi]) begin
               done_d[gi] = 1'b1;
            end else if (rd_chan[gi] || rd_last) begin
               done_d[gi] = 1'b0;
            end else begin
               done_d[gi] = done_q[gi];
            end
            if (ch_end[gi] && done_q[gi]) begin
               ovr_d[gi] = 1'b1;
            end else if (rd_stat) begin
               ovr_d[gi] = 1'b0;
            end else begin
               ovr_d[gi] = ovr_q[gi];
            end
         end
      end
   endgenerate

   // Global flags; channel reads never touch result-ready
   always_comb begin
      if (any_end) begin
         ready_d = 1'b1;
      end else if (rd_last) begin
         ready_d = 1'b0;
      end else begin
         ready_d = ready_q;
      end
      if (any_end && ready_q) begin
         govr_d = 1'b1;
      end else if (rd_stat) begin
         govr_d = 1'b0;
      end else begin
         govr_d = govr_q;
      end
   end

   // Flag registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         done_q <= '0;
         ovr_q <= '0;
         ready_q <= 1'b0;
         govr_q <= 1'b0;
      end else begin
         done_q <= done_d;
         ovr_q <= ovr_d;
         ready_q <= ready_d;
         govr_q <= govr_d;
      end
   end

   // ----------------------------------------------------------------
   // Low power
   // ----------------------------------------------------------------
   // Software selects low power, then starts one conversion to get
   // there quickly; any finished conversion counts, kept or not
   adc_sleep_ctrl u_sleep (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .lowpwr_sel(mode_lp_q),
      .start_req(start_q),
      .conv_end(conv_end),
      .sleep_q(sleep)
   );

   // ----------------------------------------------------------------
   // Read mux and bus answer
   // ----------------------------------------------------------------
   always_comb begin
      prdata_d = prdata_q;
      pready_d = access && !pready_q;
      pslverr_d = 1'b0;
      if (rd_take) begin
         prdata_d = '0;
         unique case (paddr)
            `ADC_OFS_MODE: prdata_d[`ADC_MODE_LOWPWR] = mode_lp_q;
            `ADC_OFS_CHSR: prdata_d[NCH-1:0] = chen_q;
            `ADC_OFS_STAT: begin
               prdata_d[`ADC_STAT_DONE_LSB +: NCH] = done_q;
               prdata_d[`ADC_STAT_OVR_LSB +: NCH] = ovr_q;
               prdata_d[`ADC_STAT_READY] = ready_q;
               prdata_d[`ADC_STAT_GOVR] = govr_q;
            end
            `ADC_OFS_LAST: begin
               prdata_d[`ADC_DW-1:0] = last_q;
               prdata_d[`ADC_LAST_CH_LSB +: `ADC_CHW] = last_ch_q;
            end
            default: begin
               if (in_ch) begin
                  prdata_d[`ADC_DW-1:0] = mem_rdata;
               end
            end
         endcase
      end
      if (access && !pready_q) begin
         pslverr_d = !mapped;
      end
   end

   // Bus answer registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign conv_start = start_q;
   assign chan_en = chen_q;
endmodule

`default_nettype wire

// [adc_result_flag_logic_properties.sv]
`timescale 1ns/10ps
`default_nettype none
`include "adc_flag_cfg.svh"

module adc_flag_checker (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic conv_end,
   input wire logic conv_start,
   input wire logic [`ADC_NCH-1:0] chan_en,
   input wire logic sleep
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic acc;
   // Access phase of the bus, request held
   assign acc = psel && penable;
   // ----
   // Bus steps
   // ----
   sequence s_done;
      acc && pready && pwrite;
   endsequence
   sequence s_wait_then_ready;
      !pready ##1 pready;
   endsequence
   a_one_wait: assert property ($rose(acc) |-> s_wait_then_ready)
      else $error("ready not after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_start_after_ctrl: assert property (s_done ##0
      (paddr == `ADC_OFS_CTRL && pwdata[0]) |=> conv_start ##1 !conv_start)
      else $error("start pulse missing");
   a_start_cause: assert property (conv_start |->
      $past(acc) && $past(pready) && $past(pwrite)
      && $past(paddr) == `ADC_OFS_CTRL)
      else $error("start without control write");
   a_chen_set: assert property (s_done ##0
      (paddr == `ADC_OFS_CHEN && pwdata[0]) |=> chan_en[0])
      else $error("enable not set");
   a_chdis_clr: assert property (s_done ##0
      (paddr == `ADC_OFS_CHDIS && pwdata[1]) |=> !chan_en[1])
      else $error("enable not cleared");
   // Low power is entered only on a finished conversion
   a_sleep_entry: assert property ($rose(sleep) |->
      $past(conv_end) || $past(conv_end, 2))
      else $error("sleep without conversion end");
endmodule
`default_nettype wire

// [test_adc_result_flag_logic.sv]
`timescale 1ns/10ps
`default_nettype none
`include "adc_flag_cfg.svh"

module test_adc_result_flag_logic;
   import adc_flag_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic conv_end = 1'b0;
   chan_t conv_chan = 2'h0;
   result_t conv_data = 10'h000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic conv_start;
   logic sleep;
   logic [`ADC_NCH-1:0] chan_en;
   logic [31:0] rd_q;
   logic err_q;
   int fail_count = 0;
   int tests_run = 0;

   // 10 MHz system clock
   always #50 ref_clk = ~ref_clk;

   adc_result_flag_logic u_adc_result_flag_logic (.ref_clk(ref_clk),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_end(conv_end), .conv_chan(conv_chan),
      .conv_data(conv_data), .conv_start(conv_start),
      .chan_en(chan_en), .sleep(sleep));

   // ----
   // Helpers
   // ----
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] st(input logic [3:0] dn,
         input logic [3:0] ov, input logic rdy, input logic gov);
      return {14'h0, gov, rdy, 4'h0, ov, 4'h0, dn};
   endfunction

   task automatic cv(input logic ev, input chan_t ch, input result_t v);
      conv_end <= ev;
      conv_chan <= ch;
      conv_data <= v;
   endtask

   // Bus transfer; optional end of conversion on the side-effect edge
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d, input logic ev, input chan_t ch,
         input result_t v);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      if (!wr)
         cv(ev, ch, v);
      // One assignment of conv_end per edge; a write's end lands on the
      // edge after the first access edge
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (wr && ev && !pready)
            cv(1'b1, ch, v);
         else
            conv_end <= 1'b0;
         if (pready)
            break;
         ev = 1'b0;
      end
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         fail_count++;
         summarize();
      end
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0, 1'b0, 2'h0, 10'h000);
   endtask

   task automatic wrt(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0, 2'h0, 10'h000);
   endtask

   // Idle edge after each end, so back-to-back calls never drive
   // conv_end twice in one time step
   task automatic conv(input chan_t ch, input result_t v);
      cv(1'b1, ch, v);
      @(posedge ref_clk);
      conv_end <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic do_reset(input logic [3:0] en);
      rst_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      if (en != 4'h0)
         wrt(`ADC_OFS_CHEN, {28'h0, en});
   endtask

   // ----
   // Scenarios
   // ----
   task automatic s_reset;
      do_reset(4'h0);
      chk(chan_en, 32'h0);
      rd(`ADC_OFS_STAT);
      chk(rd_q, 32'h0);
      chk(err_q, 32'h0);
      rd(`ADC_OFS_LAST);
      chk(rd_q, 32'h0);
      wrt(`ADC_OFS_CHSR, 32'hf);
      rd(`ADC_OFS_CHSR);
      chk(rd_q, 32'h0);
      rd(8'h40);
      chk(err_q, 32'h1);
      chk(rd_q, 32'h0);
   endtask

   task automatic s_store;
      do_reset(4'hf);
      chk(chan_en, 32'hf);
      conv(2'h2, 10'h155);
      rd(`ADC_OFS_STAT);
      chk(rd_q, st(4'h4, 4'h0, 1'b1, 1'b0));
      rd(8'h38);
      chk(rd_q, 32'h155);
      rd(`ADC_OFS_STAT);
      chk(rd_q, st(4'h0, 4'h0, 1'b1, 1'b0));
      rd(`ADC_OFS_LAST);
      chk(rd_q, 32'h2155);
      rd(`ADC_OFS_STAT);
      chk(rd_q, 32'h0);
   endtask

   task automatic s_ovr;
      do_reset(4'hf);
      conv(2'h1, 10'h0aa);
      conv(2'h1, 10'h0bb);
      rd(`ADC_OFS_STAT);
      chk(rd_q, st(4'h2, 4'h2, 1'b1, 1'b1));
      rd(`ADC_OFS_STAT);
      chk(rd_q, st(4'h2, 4'h0, 1'b1, 1'b0));
      apb(1'b0, `ADC_OFS_STAT, 32'h0, 1'b1, 2'h3, 10'h001);
      rd(`ADC_OFS_STAT);
      chk(rd_q, st(4'ha, 4'h0, 1'b1, 1'b1));
   endtask

   task automatic s_ovr_clear;
      do_reset(4'hf);
      conv(2'h0, 10'h001);
      conv(2'h0, 10'h002);
      rd(`ADC_OFS_LAST);
      apb(1'b0, `ADC_OFS_STAT, 32'h0, 1'b1, 2'h0, 10'h003);
      rd(`ADC_OFS_STAT);
      chk(rd_q, st(4'h1, 4'h0, 1'b1, 1'b0));
   endtask

   task automatic s_cross;
      do_reset(4'hf);
      conv(2'h1, 10'h005);
      conv(2'h3, 10'h006);
      rd(`ADC_OFS_LAST);
      chk(rd_q, 32'h3006);
      apb(1'b0, 8'h34, 32'h0, 1'b1, 2'h2, 10'h007);
      chk(rd_q, 32'h005);
      rd(`ADC_OFS_STAT);
      chk(rd_q, st(4'h4, 4'h0, 1'b1, 1'b1));
      conv(2'h3, 10'h008);
      conv(2'h0, 10'h00a);
      apb(1'b0, 8'h3c, 32'h0, 1'b1, 2'h1, 10'h009);
      chk(rd_q, 32'h008);
      rd(`ADC_OFS_STAT);
      chk(rd_q, st(4'h7, 4'h0, 1'b1, 1'b1));
   endtask

   // Disable collides with ends on other channels
   task automatic s_dis;
      do_reset(4'hf);
      conv(2'h2, 10'h001);
      apb(1'b1, `ADC_OFS_CHDIS, 32'h2, 1'b1, 2'h0, 10'h009);
      chk(chan_en, 32'hd);
      rd(`ADC_OFS_STAT);
      chk(rd_q, st(4'h5, 4'h0, 1'b1, 1'b1));
      rd(`ADC_OFS_LAST);
      chk(rd_q, 32'h0009);
      apb(1'b0, `ADC_OFS_LAST, 32'h0, 1'b1, 2'h1, 10'h3ff);
      apb(1'b0, 8'h30, 32'h0, 1'b1, 2'h1, 10'h3fe);
      chk(rd_q, 32'h009);
      rd(`ADC_OFS_STAT);
      chk(rd_q, st(4'h0, 4'h0, 1'b0, 1'b0));
      rd(`ADC_OFS_LAST);
      chk(rd_q, 32'h0009);
   endtask

   task automatic s_sleep;
      do_reset(4'h0);
      wrt(`ADC_OFS_MODE, 32'h1);
      rd(`ADC_OFS_MODE);
      chk(rd_q, 32'h1);
      repeat (4) @(posedge ref_clk);
      chk(sleep, 32'h0);
      wrt(`ADC_OFS_CTRL, 32'h1);
      conv(2'h0, 10'h010);
      repeat (3) @(posedge ref_clk);
      chk(sleep, 32'h1);
      wrt(`ADC_OFS_CTRL, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk(sleep, 32'h0);
      conv(2'h0, 10'h011);
      chk(sleep, 32'h1);
      wrt(`ADC_OFS_MODE, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk(sleep, 32'h0);
   endtask

   initial begin
      s_reset();
      s_store();
      s_ovr();
      s_ovr_clear();
      s_cross();
      s_dis();
      s_sleep();
      summarize();
   end
endmodule

bind adc_result_flag_logic adc_flag_checker u_adc_flag_checker (
   .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .conv_end(conv_end), .conv_start(conv_start),
   .chan_en(chan_en), .sleep(sleep));
`default_nettype wire
